// ---- dac_port_defs.svh ----
`ifndef DAC_PORT_DEFS_SVH
`define DAC_PORT_DEFS_SVH
// Notes on behaviour
// - The frame select is active low and bits are accepted only while it stays low.
// - Data is sampled into the shift register on each falling edge of the shift clock in a frame.
// - The input shift register is 24 bits, so one frame holds exactly 24 bits.
// - After the 24th falling edge the received code is loaded into the DAC register.
// - Frame select rising before the 24th edge aborts the frame and leaves the DAC register alone.
// - The DAC register holds an 18-bit straight binary code, zeros zero scale, ones full scale.
// - Midscale is code 0x20000, one step above 0x1ffff at the major carry.
// - A frame carries four ignored bits, 18 code bits, then two ignored bits.
// - After reset the code is zero or midscale by variant until the first complete frame.
// - The top 16 code bits are the coarse code; below coarse 0xffff the low 2 bits give a 0/25/50/75% duty of coarse+1.

// ==========================================================
// Frame layout
`define FRAME_BITS      24
`define CODE_BITS       18
`define CODE_MSB_POS    19
`define CODE_LSB_POS    2
`define COARSE_BITS     16
`define FINE_BITS       2
// ==========================================================
// Reset values and the full-scale code
`define CODE_ZERO_SCALE 18'h00000
`define CODE_MIDSCALE   18'h20000
`define CODE_FULL_SCALE 18'h3ffff
// ==========================================================
// Timing
`define SCLK_MAX_MHZ    30
`define SYNC_HIGH_NS    33
`define MCLK_MHZ        125
`endif

// ---- dac_port_pkg.sv ----
package dac_port_pkg;
  typedef enum logic {
    VARIANT_ZERO,
    VARIANT_MID
  } variant_e;
  typedef enum logic [1:0] {
    IDLE,
    SHIFT,
    DONE
  } frame_e;
endpackage

// ---- dac_interp.sv ----
`timescale 1ns/1ps
`include "dac_port_defs.svh"
// Turns the 18-bit code into a 16-bit coarse code that, below 0xffff, steps to coarse+1
// for 0, 1, 2 or 3 out of every 4 cycles.
module dac_interp (
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic [`CODE_BITS-1:0]    code,
  output logic      [`COARSE_BITS-1:0]  coarseOut
);
  logic [`FINE_BITS-1:0]   phase_q;
  logic [`FINE_BITS-1:0]   phase_d;
  logic [`COARSE_BITS-1:0] coarse_q;
  logic [`COARSE_BITS-1:0] coarse_d;
  logic [`COARSE_BITS-1:0] coarse;
  logic [`FINE_BITS-1:0]   fine;

  always_comb begin
    coarse  = code[`CODE_BITS-1:`FINE_BITS];
    fine    = code[`FINE_BITS-1:0];
    phase_d = phase_q + 2'h1;
    // Full-scale coarse stays put: no code above 0xffff exists
    if ((phase_q < fine) && (coarse != 16'hffff)) begin
      coarse_d = coarse + 16'h0001;
    end else begin
      coarse_d = coarse;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase_q  <= 2'h0;
      coarse_q <= 16'h0000;
    end else begin
      phase_q  <= phase_d;
      coarse_q <= coarse_d;
    end
  end

  assign coarseOut = coarse_q;
endmodule

// ---- dac_serial_write_port.sv ----
`timescale 1ns/1ps
`include "dac_port_defs.svh"
module dac_serial_write_port #(
  parameter dac_port_pkg::variant_e VARIANT = dac_port_pkg::VARIANT_ZERO
) (
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic                     syncN,
  input  wire logic                     sclk,
  input  wire logic                     din,
  output logic      [`CODE_BITS-1:0]    dacCode,
  output logic      [`COARSE_BITS-1:0]  coarseCode,
  output logic                          loadPulse,
  output logic                          abortPulse
);
  // ==========================================================
  // Pin synchronisers
  // Pins are packed so that one loop builds every three-stage chain
  localparam int PIN_CNT  = 3;
  localparam int PIN_SYNC = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_DIN  = 2;

  logic [PIN_CNT-1:0] pinRaw;
  logic [PIN_CNT-1:0] pinSafe;
  logic [PIN_CNT-1:0] pinPrev;
  logic               syncFall;

  // Select resets high, so leaving reset with select high never opens a frame (a select held low opens one);
  // a shift clock held high through reset shows only a harmless rise
  function automatic logic pinIdle(input int idx);
    pinIdle = (idx == PIN_SYNC);
  endfunction

  function automatic logic fellNow(input logic prev, input logic now);
    fellNow = prev & ~now;
  endfunction

  function automatic logic roseNow(input logic prev, input logic now);
    roseNow = ~prev & now;
  endfunction

  assign pinRaw = {din, sclk, syncN};

  for (genvar p = 0; p < PIN_CNT; p++) begin : g_pin
    logic meta_q;
    logic meta_d;
    logic safe_q;
    logic safe_d;
    logic prev_q;
    logic prev_d;

    // The second and third stages are read; the first may be metastable
    always_comb begin
      meta_d = pinRaw[p];
      safe_d = meta_q;
      prev_d = safe_q;
    end

    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        meta_q <= pinIdle(p);
        safe_q <= pinIdle(p);
        prev_q <= pinIdle(p);
      end else begin
        meta_q <= meta_d;
        safe_q <= safe_d;
        prev_q <= prev_d;
      end
    end

    assign pinSafe[p] = safe_q;
    assign pinPrev[p] = prev_q;
  end

  // ==========================================================
  // Frame decode
  // Shift clock is sampled at 125 MHz; a 30 MHz clock gives about two
  // samples per phase, so a faster host would lose edges
  localparam int CNT_W = $clog2(`FRAME_BITS + 1);

  logic                     sclkFall;
  logic                     syncLow;
  logic                     syncRise;
  logic                     bitTaken;
  logic                     frameDone;
  logic                     frameAbort;
  dac_port_pkg::frame_e     state_q;
  dac_port_pkg::frame_e     state_d;
  logic [`FRAME_BITS-1:0]   shift_q;
  logic [`FRAME_BITS-1:0]   shift_d;
  logic [CNT_W-1:0]         count_q;
  logic [CNT_W-1:0]         count_d;
  logic [`CODE_BITS-1:0]    code_q;
  logic [`CODE_BITS-1:0]    code_d;
  logic                     load_q;
  logic                     load_d;
  logic                     abort_q;
  logic                     abort_d;
  logic [`FRAME_BITS-1:0]   shiftIn;

  assign sclkFall   = fellNow(pinPrev[PIN_SCLK], pinSafe[PIN_SCLK]);
  assign syncFall   = fellNow(pinPrev[PIN_SYNC], pinSafe[PIN_SYNC]);
  assign syncLow    = ~pinSafe[PIN_SYNC];
  assign syncRise   = roseNow(pinPrev[PIN_SYNC], pinSafe[PIN_SYNC]);
  assign bitTaken   = (state_q == dac_port_pkg::SHIFT) & syncLow & sclkFall;
  assign frameDone  = bitTaken & (count_q == CNT_W'(`FRAME_BITS - 1));
  assign frameAbort = (state_q == dac_port_pkg::SHIFT) & ~syncLow;

  function automatic logic [`CODE_BITS-1:0] resetCode(input dac_port_pkg::variant_e v);
    resetCode = (v == dac_port_pkg::VARIANT_MID) ? `CODE_MIDSCALE : `CODE_ZERO_SCALE;
  endfunction

  // Leading and trailing filler bits are dropped here
  function automatic logic [`CODE_BITS-1:0] frameCode(input logic [`FRAME_BITS-1:0] f);
    frameCode = f[`CODE_MSB_POS:`CODE_LSB_POS];
  endfunction

  // ==========================================================
  // Frame state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dac_port_pkg::IDLE: begin
        // Frame opens only on a falling select, so a select left low after
        // a completed frame cannot start a second one
        if (syncFall) begin
          state_d = dac_port_pkg::SHIFT;
        end
      end
      dac_port_pkg::SHIFT: begin
        if (frameAbort) begin
          state_d = dac_port_pkg::IDLE;
        end else if (frameDone) begin
          state_d = dac_port_pkg::DONE;
        end
      end
      dac_port_pkg::DONE: begin
        // Extra edges are ignored until select returns high
        if (syncRise) begin
          state_d = dac_port_pkg::IDLE;
        end
      end
      default: begin
        state_d = dac_port_pkg::IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= dac_port_pkg::IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Shift register and bit count
  // Clearing on abort keeps stale bits of a cut frame out of the next
  always_comb begin
    shift_d = shift_q;
    count_d = count_q;
    shiftIn = {shift_q[`FRAME_BITS-2:0], pinSafe[PIN_DIN]};
    if (state_q == dac_port_pkg::IDLE) begin
      count_d = '0;
    end
    if (frameAbort) begin
      shift_d = '0;
    end else if (bitTaken) begin
      shift_d = shiftIn;
      count_d = count_q + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      shift_q <= '0;
      count_q <= '0;
    end else begin
      shift_q <= shift_d;
      count_q <= count_d;
    end
  end

  // ==========================================================
  // DAC register and pulses
  // Code and load pulse are registered together, so the pulse marks
  // the very cycle in which the new code first stands
  always_comb begin
    code_d  = code_q;
    load_d  = frameDone;
    abort_d = frameAbort;
    if (frameDone) begin
      code_d = frameCode(shiftIn);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      code_q  <= resetCode(VARIANT);
      load_q  <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      code_q  <= code_d;
      load_q  <= load_d;
      abort_q <= abort_d;
    end
  end

  // ==========================================================
  // Interpolator
  dac_interp dac_interp_i (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .code      (code_q),
    .coarseOut (coarseCode)
  );

  assign dacCode    = code_q;
  assign loadPulse  = load_q;
  assign abortPulse = abort_q;
endmodule

// ---- dac_serial_write_port_props.sv ----
`timescale 1ns/1ps
`include "dac_port_defs.svh"
module dac_serial_write_port_props #(
  parameter dac_port_pkg::variant_e VARIANT = dac_port_pkg::VARIANT_ZERO
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        syncN,
  input wire logic        sclk,
  input wire logic        din,
  input wire logic [17:0] dacCode,
  input wire logic [15:0] coarseCode,
  input wire logic        loadPulse,
  input wire logic        abortPulse
);
  localparam logic [17:0] RST_CODE =
    (VARIANT == dac_port_pkg::VARIANT_MID) ? `CODE_MIDSCALE : `CODE_ZERO_SCALE;
  // ==========
  // Checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_reset_code: assert property ($rose(rst_n) |-> dacCode == RST_CODE)
    else $error("reset code wrong");
  a_change_on_load: assert property ($changed(dacCode) |-> loadPulse)
    else $error("code changed without load");
  a_load_single: assert property (loadPulse |=> !loadPulse)
    else $error("load pulse too long");
  a_abort_keeps: assert property (abortPulse |=> $stable(dacCode))
    else $error("abort changed code");
  a_pulse_excl: assert property (!(loadPulse && abortPulse))
    else $error("load and abort together");
  a_abort_sync: assert property (abortPulse |-> syncN && $past(syncN, 2))
    else $error("abort without select rise");
  a_load_sclk: assert property (loadPulse |-> !sclk && $past(sclk, 2) == 1'b0)
    else $error("load not after falling edge");
  a_coarse_near: assert property (rst_n && $stable(dacCode) |=>
    coarseCode == $past(dacCode[17:2]) || coarseCode == $past(dacCode[17:2]) + 16'h1)
    else $error("coarse code off");
endmodule

// ---- dac_host_model.sv ----
`timescale 1ns/1ps
module dac_host_model (
  output logic syncN,
  output logic sclk,
  output logic din
);
  initial begin
    syncN = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  // 125 ns period keeps well under the shift clock ceiling
  task automatic frame(input logic [23:0] w, input int n);
    syncN <= 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      #62.5 din <= w[i];
      sclk <= 1'b1;
      #62.5 sclk <= 1'b0;
    end
    #62.5 sclk <= 1'b1;
    din <= ~din; // Released line shows no stale bit
    syncN <= 1'b1;
    #100;
  endtask
endmodule

// ---- dac_serial_write_port_test.sv ----
`timescale 1ns/1ps
`include "dac_port_defs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module dac_serial_write_port_test;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        syncN, sclk, din, loadPulse, abortPulse;
  logic [17:0] dacCode;
  logic [17:0] midCode;
  logic [15:0] coarseCode;
  int          error_cnt = 0, checks = 0, loads = 0, aborts = 0, hits;
  logic [17:0] codes [5] = '{18'h3ffff, 18'h1ffff, 18'h20000, 18'h00000, 18'h15555};
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) begin
    if (loadPulse === 1'b1) loads++;
    if (abortPulse === 1'b1) aborts++;
  end
  dac_host_model dac_host_model_i (.syncN(syncN), .sclk(sclk), .din(din));
  dac_serial_write_port dac_serial_write_port_i (.mclk(mclk), .rst_n(rst_n),
    .syncN(syncN), .sclk(sclk), .din(din), .dacCode(dacCode),
    .coarseCode(coarseCode), .loadPulse(loadPulse), .abortPulse(abortPulse));
  dac_serial_write_port #(.VARIANT(dac_port_pkg::VARIANT_MID)) dac_serial_write_port_mid_i (
    .mclk(mclk), .rst_n(rst_n), .syncN(syncN), .sclk(sclk), .din(din), .dacCode(midCode),
    .coarseCode(), .loadPulse(), .abortPulse());
  // ==========
  // Scenarios
  task automatic send(input logic [17:0] c, input int n);
    dac_host_model_i.frame({4'ha, c, 2'b11}, n);
    repeat (6) @(posedge mclk);
  endtask
  task automatic test_codes();
    foreach (codes[i]) begin
      send(codes[i], 24);
      `CHK("code", codes[i], dacCode)
      `CHK("mid code", codes[i], midCode)
      `CHK("loads", i + 1, loads)
    end
    $display("codes done");
  endtask
  task automatic test_abort();
    send(18'h00001, 23);
    `CHK("kept", 18'h15555, dacCode)
    `CHK("mid kept", 18'h15555, midCode)
    `CHK("aborts", 1, aborts)
    `CHK("loads", 5, loads)
    $display("abort done");
  endtask
  task automatic test_duty();
    for (int k = 0; k < 4; k++) begin
      send({16'h1234, 2'(k)}, 24);
      hits = 0;
      repeat (40) @(posedge mclk) hits += (coarseCode === 16'h1235);
      `CHK("duty", 10 * k, hits)
    end
    $display("duty done");
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    `CHK("reset", `CODE_ZERO_SCALE, dacCode)
    `CHK("mid reset", `CODE_MIDSCALE, midCode)
    test_codes();
    test_abort();
    test_duty();
    final_report();
  end
endmodule
bind dac_serial_write_port dac_serial_write_port_props #(.VARIANT(VARIANT)) props_i (
  .mclk(mclk), .rst_n(rst_n), .syncN(syncN), .sclk(sclk), .din(din), .dacCode(dacCode),
  .coarseCode(coarseCode), .loadPulse(loadPulse), .abortPulse(abortPulse));
